// [verilog/bit_branch_pkg.sv]
/*
  Shared constants and types for the bit-toggle and flag-branch executor:
  opcode patterns, phase encoding, decoded-instruction layout, reset values.
  Assumes a 16-bit instruction word and a 21-bit byte program counter.
*/
`default_nettype none
package bit_branch_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int         PC_W          = 21;
  localparam int         DADDR_W       = 14;
  localparam logic [20:0] RESET_PC     = 21'h000000;
  localparam logic [15:0] NOP_WORD     = 16'h0000;
  localparam logic [20:0] PC_STEP      = 21'h000002;

  // ==========================================================================
  // opcode patterns
  localparam logic [3:0] TOGGLE_OPC    = 4'h7;      // 0111 bbba ffff ffff
  localparam logic [7:0] OVF_BR_OPC    = 8'hE4;     // 1110 0100 nnnn nnnn
  localparam logic [7:0] ZERO_BR_OPC   = 8'hE0;     // 1110 0000 nnnn nnnn
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;     // highest indexed offset

  // ==========================================================================
  // instruction-cycle phases, gray along q1..q4
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } q_phase_type;

  typedef enum logic [1:0] {
    OP_OTHER  = 2'b00,
    OP_TOGGLE = 2'b01,
    OP_OVF_BR  = 2'b10,
    OP_ZERO_BR = 2'b11
  } op_kind_type;

  // decoded instruction fields
  typedef struct packed {
    op_kind_type kind;
    logic [2:0]  bit_idx;
    logic        access;
    logic [7:0]  file_addr;   // doubles as branch offset
  } decoded_type;

endpackage
`default_nettype wire

// [verilog/bank_addr_former.sv]
/*
  Forms the 14-bit data address of a bit-oriented instruction from the
  access flag, file address, bank select value and extended-mode state.
  Assumes the indexed base register value is supplied by the core.
*/
`timescale 1ns/1ps
`default_nettype none
module bank_addr_former #(
  parameter logic [13:0] ACCESS_HIGH_BASE = 14'h0000
) (
  input  wire logic [7:0]  file_addr,
  input  wire logic        access,
  input  wire logic [5:0]  bank_select_reg,
  input  wire logic        ext_set_en,
  input  wire logic [13:0] index_base,
  output logic      [13:0] data_addr
);

  // ==========================================================================
  // address selection
  always_comb begin
    if (access) begin
      data_addr = {bank_select_reg, file_addr};
    end else if (ext_set_en && (file_addr <= bit_branch_pkg::INDEXED_LIMIT)) begin
      data_addr = 14'(index_base + {6'h00, file_addr});
    end else if (file_addr <= bit_branch_pkg::INDEXED_LIMIT) begin
      data_addr = {6'h00, file_addr};
    end else begin
      data_addr = ACCESS_HIGH_BASE | {6'h00, file_addr}; // access bank high part
    end
  end

endmodule
`default_nettype wire

// [verilog/bit_toggle_and_flag_branch_exec.sv]
/*
  Executor for the bit toggle and the overflow/zero conditional branches,
  sequenced over the four phases of each instruction cycle.
  Assumes a fetch port returning the word at fetch_addr by phase q4, and a
  data port returning rd_data within q2, by the end of q2, for an address driven at q2.
  Status flags are inputs only: no path in this block writes a flag.
  Every output comes straight from a register; strobes last one phase.
  A word that is not one of the three handled opcodes runs as a no-op.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_and_flag_branch_exec #(
  parameter logic [13:0] ACCESS_HIGH_BASE = 14'h0000
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [15:0] fetch_data,
  input  wire logic        ext_set_en,
  input  wire logic [5:0]  bank_select_reg,
  input  wire logic [13:0] index_base,
  input  wire logic        flag_zero,
  input  wire logic        flag_overflow,
  input  wire logic [7:0]  rd_data,
  output logic      [20:0] fetch_addr,
  output logic      [1:0]  q_phase,
  output logic      [13:0] data_addr,
  output logic             data_rd_en,
  output logic             data_wr_en,
  output logic      [7:0]  data_wr_data,
  output logic             branch_flush
);

  // ==========================================================================
  // state
  // phase, held word, pc and the no-op marker form the instruction pipeline
  bit_branch_pkg::q_phase_type phase_reg, phase_next;
  logic [15:0] ir_reg, ir_next;
  logic [20:0] pc_reg, pc_next;
  logic        nop_cycle_reg, nop_cycle_next;
  logic [13:0] daddr_reg, daddr_next;
  logic        rd_en_reg, rd_en_next;
  logic        wr_en_reg, wr_en_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        flush_reg, flush_next;
  // combinational helpers, not registered
  bit_branch_pkg::decoded_type dec;
  logic [13:0] formed_addr;
  logic        taken;
  logic [20:0] offset_ext;
  logic [20:0] target_pc;
  logic [20:0] seq_pc;

  // ==========================================================================
  // decode of the held instruction word
  always_comb begin
    // fields are taken apart unconditionally; only the kind depends on opcode
    dec.bit_idx   = ir_reg[11:9];
    dec.access    = ir_reg[8];
    dec.file_addr = ir_reg[7:0];
    if (nop_cycle_reg) begin
      dec.kind = bit_branch_pkg::OP_OTHER;   // flushed slot executes nothing
    end else if (ir_reg[15:12] == bit_branch_pkg::TOGGLE_OPC) begin
      dec.kind = bit_branch_pkg::OP_TOGGLE;
    end else if (ir_reg[15:8] == bit_branch_pkg::OVF_BR_OPC) begin
      dec.kind = bit_branch_pkg::OP_OVF_BR;
    end else if (ir_reg[15:8] == bit_branch_pkg::ZERO_BR_OPC) begin
      dec.kind = bit_branch_pkg::OP_ZERO_BR;
    end else begin
      dec.kind = bit_branch_pkg::OP_OTHER;
    end
  end

  // flags are only read here; this block has no status write path at all
  always_comb begin
    case (dec.kind)
      bit_branch_pkg::OP_OVF_BR:  taken = flag_overflow;
      bit_branch_pkg::OP_ZERO_BR: taken = flag_zero;
      default:                taken = 1'b0;
    endcase
    offset_ext = {{12{dec.file_addr[7]}}, dec.file_addr, 1'b0};
  end

  // next fetch addresses; the pc already points past the branch word, so
  // adding another two here would land one word beyond the target
  always_comb begin
    target_pc = 21'(pc_reg + offset_ext);
    // sequential step to the following word
    seq_pc    = 21'(pc_reg + bit_branch_pkg::PC_STEP);
  end

  // the address former is combinational; its result is only latched in q1
  bank_addr_former #(
    .ACCESS_HIGH_BASE (ACCESS_HIGH_BASE)
  ) u_addr (
    .file_addr       (dec.file_addr),
    .access          (dec.access),
    .bank_select_reg (bank_select_reg),
    .ext_set_en      (ext_set_en),
    .index_base      (index_base),
    .data_addr       (formed_addr)
  );

  // ==========================================================================
  // phase sequencing and execution
  // one instruction cycle is four clocks:
  //   q1 decode and latch the data address
  //   q2 read strobe; the byte is captured at the end of q2
  //   q3 write strobe armed with the modified byte
  //   q4 write back; take the next word, or redirect the pc on a taken branch
  // a taken branch spends the following cycle as a no-op
  always_comb begin
    phase_next     = phase_reg;
    ir_next        = ir_reg;
    pc_next        = pc_reg;
    nop_cycle_next = nop_cycle_reg;
    daddr_next     = daddr_reg;
    rd_en_next     = 1'b0;
    wr_en_next     = 1'b0;
    wdata_next     = wdata_reg;
    flush_next     = 1'b0;
    case (phase_reg)
      bit_branch_pkg::PH_Q1: begin
        phase_next = bit_branch_pkg::PH_Q2;
        if (dec.kind == bit_branch_pkg::OP_TOGGLE) begin
          // latch formed address
          // frozen here, so later bank or index changes cannot move the write
          daddr_next = formed_addr;
          rd_en_next = 1'b1;     // read strobe spans q2
        end
      end
      bit_branch_pkg::PH_Q2: begin
        phase_next = bit_branch_pkg::PH_Q3;
        if (dec.kind == bit_branch_pkg::OP_TOGGLE) begin
          // invert selected bit
          // a single-bit mask keeps the other seven bits as read
          wdata_next = rd_data ^ (8'h01 << dec.bit_idx);
        end
      end
      bit_branch_pkg::PH_Q3: begin
        phase_next = bit_branch_pkg::PH_Q4;
        wr_en_next = (dec.kind == bit_branch_pkg::OP_TOGGLE);
      end
      bit_branch_pkg::PH_Q4: begin
        phase_next = bit_branch_pkg::PH_Q1;
        if (taken) begin
          pc_next        = target_pc;
          nop_cycle_next = 1'b1;
          flush_next     = 1'b1;
        end else begin
          // sequential fetch completes; during a no-op cycle this is the target
          ir_next        = fetch_data;
          pc_next        = seq_pc;
          nop_cycle_next = 1'b0;
        end
      end
      default: begin
        // unreachable with the four gray codes; recover to q1
        phase_next = bit_branch_pkg::PH_Q1;
      end
    endcase
  end

  // registers; reset starts with a no-op so the first cycle fetches RESET_PC
  // only constants in the reset branch, so release cannot load stale data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg     <= bit_branch_pkg::PH_Q1;
      ir_reg        <= bit_branch_pkg::NOP_WORD;
      pc_reg        <= bit_branch_pkg::RESET_PC;
      nop_cycle_reg <= 1'b0;
      daddr_reg     <= 14'h0000;
      rd_en_reg     <= 1'b0;
      wr_en_reg     <= 1'b0;
      wdata_reg     <= 8'h00;
      flush_reg     <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      ir_reg        <= ir_next;
      pc_reg        <= pc_next;
      nop_cycle_reg <= nop_cycle_next;
      daddr_reg     <= daddr_next;
      rd_en_reg     <= rd_en_next;
      wr_en_reg     <= wr_en_next;
      wdata_reg     <= wdata_next;
      flush_reg     <= flush_next;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  // no logic after the registers keeps the pin timing to one flop level
  assign fetch_addr   = pc_reg;
  assign q_phase      = phase_reg;
  assign data_addr    = daddr_reg;
  assign data_rd_en   = rd_en_reg;
  assign data_wr_en   = wr_en_reg;
  assign data_wr_data = wdata_reg;
  assign branch_flush = flush_reg;

endmodule
`default_nettype wire

// [dv/bit_branch_checker.sv]
/*
  Port-level checker for the bit toggle and flag branch executor.
  Assumes the phase encoding and constants of bit_branch_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_branch_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  rd_data,
  input wire logic [20:0] fetch_addr,
  input wire logic [1:0]  q_phase,
  input wire logic [13:0] data_addr,
  input wire logic        data_rd_en,
  input wire logic        data_wr_en,
  input wire logic [7:0]  data_wr_data,
  input wire logic        branch_flush
);
  // ==========================================================
  // phase, data and fetch relations
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_PHASE_RING: assert property (q_phase == 2'b00 |=> q_phase == 2'b01 ##1
    q_phase == 2'b11 ##1 q_phase == 2'b10 ##1 q_phase == 2'b00) else $error("phase ring broken");
  AST_RD_IN_Q2: assert property (data_rd_en |-> q_phase == 2'b01)
    else $error("read strobe outside q2");
  AST_WR_AFTER_RD: assert property (data_rd_en |-> ##2 data_wr_en)
    else $error("write strobe not two clocks after read");
  AST_ADDR_HELD: assert property (data_rd_en |=> $stable(data_addr) [*3])
    else $error("data address moved during toggle");
  AST_ONE_BIT: assert property (data_wr_en |-> $onehot(data_wr_data ^ $past(rd_data, 2)))
    else $error("toggle changed other than one bit");
  AST_FLUSH_IDLE: assert property (branch_flush |-> q_phase == 2'b00 ##0 !data_rd_en [*4])
    else $error("flush cycle not a no-op");
  AST_PC_HOLD: assert property (q_phase != 2'b10 |=> $stable(fetch_addr))
    else $error("fetch address moved outside q4");
  AST_PC_STEP: assert property (q_phase == 2'b10 ##1 !branch_flush
    |-> fetch_addr == $past(fetch_addr) + 21'h000002) else $error("sequential step wrong");
  AST_PC_EVEN: assert property (fetch_addr[0] == 1'b0)
    else $error("odd fetch address");
  // main scenarios reached
  CV_FLUSH: cover property (branch_flush);
  CV_TOGGLE: cover property (data_rd_en ##2 data_wr_en);
  CV_SEQ: cover property (q_phase == 2'b10 ##1 !branch_flush);
endmodule
bind bit_toggle_and_flag_branch_exec bit_branch_checker i_chk (.clk_sys, .rst_n, .rd_data,
  .fetch_addr, .q_phase, .data_addr, .data_rd_en, .data_wr_en, .data_wr_data, .branch_flush);
`default_nettype wire

// [dv/bit_toggle_and_flag_branch_exec_tb.sv]
/*
  Self-checking bench: feeds instruction words at q4, checks toggles and branches.
  Assumes the design's fetch sampling at the end of q4.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_and_flag_branch_exec_tb;
  logic clk_sys, rst_n, ext_set_en, flag_zero, flag_overflow;
  logic [15:0] fetch_data;
  logic [5:0]  bank_select_reg;
  logic [13:0] index_base, data_addr;
  logic [7:0]  rd_data, data_wr_data;
  logic [20:0] fetch_addr;
  logic [1:0]  q_phase;
  logic        data_rd_en, data_wr_en, branch_flush;
  int          n_fail, n_tests, cycles;
  bit_toggle_and_flag_branch_exec i_dut (.clk_sys, .rst_n, .fetch_data, .ext_set_en,
    .bank_select_reg, .index_base, .flag_zero, .flag_overflow, .rd_data, .fetch_addr,
    .q_phase, .data_addr, .data_rd_en, .data_wr_en, .data_wr_data, .branch_flush);
  // ==========================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios; words are placed on the fetch bus during q4
  task automatic do_reset;
    rst_n = 1'b0;
    fetch_data = 16'h0000;
    repeat (12) @(posedge clk_sys);
    #1 check("reset pc", fetch_addr, 21'h0);
    check("reset phase", q_phase, 21'h0);
    rst_n = 1'b1;
  endtask
  task automatic feed(input logic [15:0] w, output logic [20:0] a);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (q_phase !== 2'b10 && k < 8);
    a = fetch_addr;
    fetch_data = w;
  endtask
  task automatic toggle_case(input logic a, input logic ext, input logic [7:0] f,
                             input logic [2:0] b, input logic [13:0] exp_addr);
    logic [20:0] pc;
    ext_set_en = ext;
    rd_data = f ^ 8'h5A;
    feed({4'h7, b, a, f}, pc);
    repeat (2) @(posedge clk_sys);
    #1 check("rd_en", data_rd_en, 21'h1);
    check("rd_addr", data_addr, exp_addr);
    feed(16'h0000, pc);
    check("wr_en", data_wr_en, 21'h1);
    check("wr_data", data_wr_data, rd_data ^ (8'h01 << b));
    check("data_addr", data_addr, exp_addr);
  endtask
  task automatic bit_sweep;
    for (int b = 0; b < 8; b++) begin
      toggle_case(1'b0, 1'b0, 8'h40, b[2:0], 14'h0040);
    end
  endtask
  task automatic branch_case(input logic [7:0] opc, input logic [7:0] n,
                             input logic z, input logic v, input logic tk);
    logic [20:0] a, d;
    flag_zero = z;
    flag_overflow = v;
    feed({opc, n}, a);
    // the word behind the branch is a toggle, which a taken branch must drop
    feed(16'h7040, d);
    @(posedge clk_sys);
    #1 check("pc", fetch_addr, tk ? a + 21'h2 + {{12{n[7]}}, n, 1'b0} : a + 21'h4);
    check("flush", branch_flush, {20'h0, tk});
    repeat (3) @(posedge clk_sys);
    #1 check("slot_wr", data_wr_en, {20'h0, !tk});
  endtask
  initial begin
    {ext_set_en, flag_zero, flag_overflow, rd_data} = '0;
    bank_select_reg = 6'h2B;
    index_base = 14'h1200;
    do_reset();
    bit_sweep();
    toggle_case(1'b0, 1'b0, 8'hA7, 3'h7, 14'h00A7);
    toggle_case(1'b1, 1'b0, 8'h34, 3'h3, 14'h2B34);
    toggle_case(1'b0, 1'b1, 8'h5F, 3'h5, 14'h125F);
    toggle_case(1'b0, 1'b1, 8'h60, 3'h1, 14'h0060);
    toggle_case(1'b1, 1'b1, 8'h05, 3'h6, 14'h2B05);
    branch_case(8'hE0, 8'h80, 1'b1, 1'b0, 1'b1);
    branch_case(8'hE0, 8'h7F, 1'b0, 1'b1, 1'b0);
    branch_case(8'hE0, 8'h7F, 1'b1, 1'b0, 1'b1);
    branch_case(8'hE4, 8'h05, 1'b0, 1'b1, 1'b1);
    branch_case(8'hE4, 8'hFB, 1'b1, 1'b0, 1'b0);
    branch_case(8'hE1, 8'h10, 1'b1, 1'b1, 1'b0);
    do_reset();
    branch_case(8'hE4, 8'h01, 1'b0, 1'b1, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
